// ### cswc_cfg.svh
// Constants for the clock-stop wake control block.
// Assumes inclusion by bare name; definitions only.
`ifndef CSWC_CFG_SVH
`define CSWC_CFG_SVH

`define CSWC_NUM_INT        4
`define CSWC_INT_BLANK_CYC  3
`define CSWC_DMA_CLR_CYC    3
`define CSWC_WAKE_HOLD_CYC  1
`define CSWC_RESTART_DLY    1
`define CSWC_CLK_NS         50

`endif

// ### cswc_pkg.sv
// Types for the clock-stop wake control block.
// Assumes cswc_cfg.svh is on the include path.
package cswc_pkg;
    typedef enum logic [1:0] {
        CSWC_RUN,
        CSWC_STOPPED,
        CSWC_RESTART
    } cswc_state_t;
endpackage

// ### cswc_int_flag.sv
// One interrupt flag with reset clear, start-up blanking and two clear sources.
// Assumes lines are active low and synchronous to clk.
`timescale 1ns/1ns
`default_nettype none
`include "cswc_cfg.svh"
module cswc_int_flag #(
    parameter int DMA_CLR_CYC = `CSWC_DMA_CLR_CYC
) (
    input  wire logic clk,        // System clock
    input  wire logic arst_n,     // Async reset, active low
    input  wire logic blank,      // Flag setting blocked after reset
    input  wire logic lineN,      // Interrupt line, active low
    input  wire logic dmaOwn,     // DMA services this flag
    input  wire logic swClear,    // Software clear pulse
    output logic      flag        // Interrupt flag
);
    logic       lineLast_reg;
    logic [3:0] age_reg;
    logic [3:0] age_next;
    logic       flag_next;
    wire        fall     = lineLast_reg & ~lineN;
    wire        setEv    = fall & ~blank;
    wire        dmaClear = dmaOwn & flag & (age_reg == 4'(DMA_CLR_CYC - 1));
    // Age saturates so a long-held flag never wraps into a late DMA clear
    wire [3:0]  ageStep  = (age_reg == 4'hf) ? age_reg : age_reg + 4'h1;

    initial begin
        if (DMA_CLR_CYC < 1 || DMA_CLR_CYC > 15) $error("DMA_CLR_CYC out of range");
    end

    // Set beats a clear landing in the same cycle
    assign flag_next = setEv | (flag & ~swClear & ~dmaClear);
    assign age_next  = setEv ? 4'h1 : (flag ? ageStep : 4'h0);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            flag         <= 1'b0;
            lineLast_reg <= 1'b1;
            age_reg      <= 4'h0;
        end else begin
            flag         <= flag_next;
            lineLast_reg <= lineN;
            age_reg      <= age_next;
        end
    end
endmodule
`default_nettype wire

// ### cswc_core.sv
// Clock-stop wake control: gates core clock, drives the two output clocks,
// wakes on an interrupt line or (revised variant) on reset.
// Assumes clk free running (board keeps it alive) and pins synchronous to clk.
//
// Behaviour
// - Baseline: reset registered by output clocks first.
// - Revised: reset pin forces clocks running at the next clk edge.
// - Baseline: only low interrupt line wakes.
// - Reset clears flags; none set first three cycles.
// - Blanking counts output clock periods; DMA clear and wake counts are clk cycles.
// - DMA may clear flag in third cycle only.
// - Software may clear a flag explicitly.
// - Wake latch: low line releases and beats a halt set.
// - Stopped: primary clock high, secondary low.
// - Line held one cycle, restart one later.
`timescale 1ns/1ns
`default_nettype none
`include "cswc_cfg.svh"
module cswc_core #(
    parameter int NUM_INT     = `CSWC_NUM_INT,
    parameter bit RESET_WAKES = 1'b0,
    parameter int BLANK_CYC   = `CSWC_INT_BLANK_CYC
) (
    input  wire logic               clk,                  // Input clock, free running
    input  wire logic               arst_n,               // Async reset, active low
    input  wire logic               extResetN,            // Board reset pin, active low
    input  wire logic [NUM_INT-1:0] externalInterruptLines, // Active low lines
    input  wire logic               emulationActive,      // Emulator present
    input  wire logic               coreClockHaltRequest, // Core asks to stop, held until taken on an output-clock tick
    input  wire logic [NUM_INT-1:0] dmaOwn,               // DMA services line i
    input  wire logic [NUM_INT-1:0] swFlagClear,          // Software clear pulses
    output logic                    primaryOutputClock,   // Primary output clock
    output logic                    secondaryOutputClock, // Secondary output clock
    output logic                    coreClockEnable,      // Core clock gate
    output logic                    clockStopIdle,        // In clock-stop idle
    output logic [NUM_INT-1:0]      intFlags              // Interrupt flags
);
    initial begin
        if (NUM_INT < 1 || NUM_INT > 8) $error("NUM_INT out of range");
        if (BLANK_CYC < 1 || BLANK_CYC > 7) $error("BLANK_CYC out of range");
    end

    // ------------------------------------------------------------------
    // Constants and state decode
    // ------------------------------------------------------------------
    localparam int         DMA_CLR_CYC = `CSWC_DMA_CLR_CYC;
    localparam logic [2:0] BLANK_LOAD  = 3'(BLANK_CYC);

    // Output clocks run only in the run state; restart still keeps them parked
    function automatic logic runsIn(cswc_pkg::cswc_state_t s);
        return (s == cswc_pkg::CSWC_RUN);
    endfunction

    function automatic logic stoppedIn(cswc_pkg::cswc_state_t s);
        return (s == cswc_pkg::CSWC_STOPPED);
    endfunction

    // ------------------------------------------------------------------
    // Output clock phase and reset paths
    // ------------------------------------------------------------------
    cswc_pkg::cswc_state_t state_reg;
    cswc_pkg::cswc_state_t state_next;
    logic       phase_reg;
    logic       resetSync_reg;
    logic [2:0] blankCnt_reg;
    logic       lowSeen_reg;

    // Registered on output-clock ticks only, so it cannot move while stopped
    wire clocksRun  = runsIn(state_reg);
    wire tick       = clocksRun & phase_reg;
    wire anyLineLow = ~&externalInterruptLines;
    // Revised: raw pin reaches the latch; baseline: pin never wakes, clocked copy blocks halt and reloads blanking
    wire resetWake  = RESET_WAKES ? ~extResetN : 1'b0;
    wire internalReset = RESET_WAKES ? ~extResetN : resetSync_reg;
    wire blank      = (blankCnt_reg != 3'h0) | internalReset;
    wire haltOk     = coreClockHaltRequest & ~emulationActive & ~internalReset;

    // ------------------------------------------------------------------
    // Wake and halt decode
    // ------------------------------------------------------------------
    // A low line wins over a halt offered in the same cycle
    wire haltTaken  = haltOk & tick & ~anyLineLow & ~resetWake;
    // Low on two stopped edges in a row, so a one-edge glitch cannot wake
    wire lineWake   = anyLineLow & lowSeen_reg;
    wire lowNext    = anyLineLow & stoppedIn(state_reg);
    // Outputs and phase follow the next state so they move together
    wire runNext    = runsIn(state_next);
    wire stopNext   = ~runNext;
    wire phaseNext  = runNext ? ~phase_reg : 1'b1;

    // ------------------------------------------------------------------
    // Reset paths
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            resetSync_reg <= 1'b1;
        end else if (tick) begin
            resetSync_reg <= ~extResetN;
        end
    end

    // ------------------------------------------------------------------
    // Start-up blanking
    // ------------------------------------------------------------------
    // Blanking counts output clock cycles after reset deasserts
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            blankCnt_reg <= BLANK_LOAD;
        end else if (internalReset) begin
            blankCnt_reg <= BLANK_LOAD;
        end else if (tick && blankCnt_reg != 3'h0) begin
            blankCnt_reg <= blankCnt_reg - 3'h1;
        end
    end

    // ------------------------------------------------------------------
    // Wake latch
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            cswc_pkg::CSWC_RUN: begin
                if (haltTaken) begin
                    state_next = cswc_pkg::CSWC_STOPPED;
                end
            end
            cswc_pkg::CSWC_STOPPED: begin
                // Reset wake dominates; line must be seen low a full cycle
                if (resetWake) begin
                    state_next = cswc_pkg::CSWC_RUN;
                end else if (lineWake) begin
                    state_next = cswc_pkg::CSWC_RESTART;
                end
            end
            cswc_pkg::CSWC_RESTART: begin
                state_next = cswc_pkg::CSWC_RUN;
            end
            default: begin
                state_next = cswc_pkg::CSWC_RUN;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= cswc_pkg::CSWC_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    // Phase tracks the next state, so the first edge after a restart is a fall
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            phase_reg <= 1'b0;
        end else begin
            phase_reg <= phaseNext;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lowSeen_reg <= 1'b0;
        end else begin
            lowSeen_reg <= lowNext;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all registered
    // ------------------------------------------------------------------
    // Stopped: primary parks high, secondary low; the pair never overlaps
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            primaryOutputClock   <= 1'b0;
            secondaryOutputClock <= 1'b1;
        end else begin
            primaryOutputClock   <= stopNext ? 1'b1 : phaseNext;
            secondaryOutputClock <= stopNext ? 1'b0 : ~phaseNext;
        end
    end

    // Core clock gate opens together with the output clocks, never before
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            coreClockEnable <= 1'b1;
            clockStopIdle   <= 1'b0;
        end else begin
            coreClockEnable <= runNext;
            clockStopIdle   <= stopNext;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt flags
    // ------------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < NUM_INT; i++) begin : gFlag
            // One flag per line; blanking is shared so all lines open together
            cswc_int_flag #(
                .DMA_CLR_CYC(DMA_CLR_CYC)
            ) uFlag (
                .clk     (clk),
                .arst_n  (arst_n),
                .blank   (blank),
                .lineN   (externalInterruptLines[i]),
                .dmaOwn  (dmaOwn[i]),
                .swClear (swFlagClear[i]),
                .flag    (intFlags[i])
            );
        end
    endgenerate
endmodule
`default_nettype wire

// ### cswc_core_assertions.sv
// Port checker for the clock-stop wake core.
// Assumes it is bound to every core instance.
`timescale 1ns/1ns
`default_nettype none
module cswc_core_assertions #(
    parameter int NUM_INT     = 4,
    parameter bit RESET_WAKES = 1'b0
) (
    input wire logic               clk,                    // Clock
    input wire logic               arst_n,                 // Reset
    input wire logic               extResetN,              // Pin reset
    input wire logic [NUM_INT-1:0] externalInterruptLines, // Lines
    input wire logic               emulationActive,        // Emulator
    input wire logic               coreClockHaltRequest,   // Halt
    input wire logic [NUM_INT-1:0] dmaOwn,                 // DMA owns
    input wire logic [NUM_INT-1:0] swFlagClear,            // Sw clear
    input wire logic               primaryOutputClock,     // Primary
    input wire logic               secondaryOutputClock,   // Secondary
    input wire logic               coreClockEnable,        // Gate
    input wire logic               clockStopIdle,          // Stopped
    input wire logic [NUM_INT-1:0] intFlags                // Flags
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    property p_stop_lvl; clockStopIdle |-> primaryOutputClock && !secondaryOutputClock; endproperty
    a_stop_lvl: assert property (p_stop_lvl) else $error("stopped clock levels");
    property p_tog; $past(arst_n) && !clockStopIdle && !$past(clockStopIdle)
        |-> primaryOutputClock != $past(primaryOutputClock); endproperty
    a_tog: assert property (p_tog) else $error("output clock not toggling");
    property p_wake; clockStopIdle && !(&externalInterruptLines) ##1 !(&externalInterruptLines) |-> ##[1:3] !clockStopIdle;
    endproperty
    a_wake: assert property (p_wake) else $error("late wake");
    property p_hold; (clockStopIdle && (&externalInterruptLines) && (!RESET_WAKES || extResetN))[*4] |=> clockStopIdle;
    endproperty
    a_hold: assert property (p_hold) else $error("woke without a line");
    property p_rwake; RESET_WAKES && clockStopIdle && !extResetN |=> !clockStopIdle; endproperty
    a_rwake: assert property (p_rwake) else $error("pin reset did not wake");
    property p_blank; $rose(arst_n) |-> (intFlags == '0)[*6]; endproperty
    a_blank: assert property (p_blank) else $error("flag set after reset");
    property p_dma; $rose(intFlags[0]) && dmaOwn[0] |-> ##[1:3] !intFlags[0]; endproperty
    a_dma: assert property (p_dma) else $error("dma clear late");
    property p_swclr; swFlagClear[1] && (&externalInterruptLines) |=> !intFlags[1]; endproperty
    a_swclr: assert property (p_swclr) else $error("software clear lost");
    property p_pair; secondaryOutputClock != primaryOutputClock; endproperty
    a_pair: assert property (p_pair) else $error("output clocks overlap");
    property p_gate; coreClockEnable != clockStopIdle; endproperty
    a_gate: assert property (p_gate) else $error("core gate disagrees with idle");
endmodule
bind cswc_core cswc_core_assertions #(.NUM_INT(NUM_INT), .RESET_WAKES(RESET_WAKES)) chk_u (.*);
`default_nettype wire

// ### cswc_board_model.sv
// Board logic driving the reset pin and interrupt lines.
// Assumes clk is the core input clock.
`timescale 1ns/1ns
`default_nettype none
module cswc_board_model (
    input  wire logic       clk,       // Clock
    input  wire logic       arst_n,    // Power-up reset
    input  wire logic       rstHold,   // Pull pin reset low
    input  wire logic [3:0] pulseMask, // Lines to pulse
    input  wire logic [2:0] pulseLen,  // Pulse width in clk
    output logic            extResetN, // Pin reset
    output logic [3:0]      lines      // Interrupt lines
);
    logic [3:0] bootCnt;
    logic [2:0] pulseCnt;
    logic [3:0] pulseReg;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            extResetN <= 1'b0;
            lines     <= 4'b1110;
            bootCnt   <= 4'h0;
            pulseCnt  <= 3'h0;
            pulseReg  <= 4'h0;
        end else begin
            extResetN <= !rstHold;
            if (bootCnt < 4'h8) bootCnt <= bootCnt + 4'h1; // Boot line low four output cycles
            if (pulseCnt != 3'h0) pulseCnt <= pulseCnt - 3'h1;
            else if (|pulseMask) begin
                pulseCnt <= pulseLen;
                pulseReg <= pulseMask;
            end
            lines <= {3'b111, bootCnt >= 4'h8} & ~((pulseCnt != 3'h0) ? pulseReg : 4'h0);
        end
    end
endmodule
`default_nettype wire

// ### clock_stop_wake_control_tb.sv
// Self-checking bench for the clock-stop wake core.
// Assumes the board model and both core variants.
`timescale 1ns/1ns
`default_nettype none
module clock_stop_wake_control_tb;
    logic       clk = 1'b0, arst_n = 1'b0, emu = 1'b0, halt = 1'b0, rstHold = 1'b0;
    logic [3:0] dma = 4'h0, swClr = 4'h0, pMask = 4'h0, m, lines, flags;
    logic [2:0] pLen = 3'h2;
    logic       extResetN, idle, idle1, pri, sec, en;
    integer     seed = 32'he987_3c4f;
    int         failures = 0, checked = 0, cycles = 0, n;
    cswc_board_model bm_u (.clk(clk), .arst_n(arst_n), .rstHold(rstHold), .pulseMask(pMask), .pulseLen(pLen),
        .extResetN(extResetN), .lines(lines));
    cswc_core dut_u (.clk(clk), .arst_n(arst_n), .extResetN(extResetN), .externalInterruptLines(lines),
        .emulationActive(emu), .coreClockHaltRequest(halt), .dmaOwn(dma), .swFlagClear(swClr),
        .primaryOutputClock(pri), .secondaryOutputClock(sec), .coreClockEnable(en), .clockStopIdle(idle), .intFlags(flags));
    cswc_core #(.RESET_WAKES(1'b1)) dutRev_u (.clk(clk), .arst_n(arst_n), .extResetN(extResetN),
        .externalInterruptLines(lines), .emulationActive(emu), .coreClockHaltRequest(halt), .dmaOwn(dma),
        .swFlagClear(swClr), .primaryOutputClock(), .secondaryOutputClock(), .coreClockEnable(),
        .clockStopIdle(idle1), .intFlags());
    always #25 clk = ~clk; // Input clock never stops
    function automatic logic [3:0] expFlags(logic [3:0] set, logic [3:0] own);
        return set & ~own;
    endfunction
    task automatic chk(string name, logic [3:0] exp, logic [3:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic pulse(logic [3:0] mask);
        @(posedge clk) pMask <= mask;
        @(posedge clk) pMask <= 4'h0;
    endtask
    task automatic report_and_stop;
        if (failures == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            failures++;
            report_and_stop();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        pulse(4'h2); // Falls inside blanking, must leave no flag
        repeat (12) @(negedge clk);
        chk("flags after reset", 4'h0, flags);
        for (n = 0; n < 20; n++) begin
            m = 4'($random(seed));
            @(posedge clk) dma <= 4'($random(seed));
            pLen <= 3'h3 + 3'($random(seed) & 1); // Over one, at most two output cycles
            pulse(m);
            repeat (6) @(negedge clk);
            chk("flags", expFlags(m, dma), flags);
            @(posedge clk) swClr <= 4'hf;
            @(posedge clk) swClr <= 4'h0;
            @(negedge clk) chk("flags cleared", 4'h0, flags);
        end
        @(posedge clk) emu <= 1'b1;
        halt <= 1'b1;
        repeat (10) @(negedge clk);
        chk("halt under emulation", 4'h0, {3'b0, idle});
        @(posedge clk) emu <= 1'b0;
        for (n = 0; n < 10 && idle !== 1'b1; n++) @(negedge clk);
        chk("stopped outputs", 4'b1100, {idle, pri, sec, en});
        chk("revised stopped", 4'h1, {3'b0, idle1});
        @(posedge clk) halt <= 1'b0;
        rstHold <= 1'b1;
        repeat (4) @(negedge clk);
        chk("pin reset while stopped", 4'b0010, {2'b0, idle, idle1});
        @(posedge clk) rstHold <= 1'b0;
        pLen <= 3'h3;
        pulse(4'h4);
        for (n = 0; n < 8 && idle !== 1'b0; n++) @(negedge clk);
        chk("woken by line", 4'h0, {3'b0, idle});
        report_and_stop();
    end
endmodule
`default_nettype wire
